// ===== hw/mpwm_pkg.sv
// package of shared constants and types for the multi-group pwm generator
package mpwm_pkg;
	localparam int MPWM_GROUPS = 4;
	localparam int MPWM_OUTS_PER_GROUP = 4;
	localparam int MPWM_CHANNELS = 2;
	localparam int MPWM_CNT_W = 16;
	localparam logic [15:0] MPWM_PERIOD_RESET = 16'h00FF;
	localparam logic [15:0] MPWM_DUTY_RESET = 16'h0000;
	localparam logic [15:0] MPWM_CNT_RESET = 16'h0000;
	typedef enum logic [1:0] {
		MPWM_PH_IDLE = 2'b00,
		MPWM_PH_UP = 2'b01,
		MPWM_PH_DOWN = 2'b10
	} mpwm_phase_type;
endpackage

// ===== hw/mpwm_group_if.sv
// carrier between the top and one pwm group core
`timescale 1ns/100ps
interface mpwm_group_if;
	import mpwm_pkg::*;
	logic enable;
	logic center_mode;
	logic double_update;
	logic paired;
	logic [MPWM_CNT_W-1:0] period;
	logic [MPWM_CNT_W-1:0] duty [MPWM_OUTS_PER_GROUP];
	logic [MPWM_OUTS_PER_GROUP-1:0] outs;
	logic period_start;
	modport top (output enable, center_mode, double_update, paired, period, duty, input outs, period_start);
	modport core (input enable, center_mode, double_update, paired, period, duty, output outs, period_start);
endinterface

// ===== hw/mpwm_group.sv
// one pwm group: counter, shadow duties and four compare outputs
`timescale 1ns/100ps
module mpwm_group
	import mpwm_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	mpwm_group_if.core gi
);
	mpwm_phase_type phase_reg, phase_next;
	logic [MPWM_CNT_W-1:0] cnt_reg, cnt_next;
	logic [MPWM_CNT_W-1:0] period_reg;
	logic [MPWM_CNT_W-1:0] act_reg [MPWM_OUTS_PER_GROUP];
	logic [MPWM_OUTS_PER_GROUP-1:0] outs_reg;
	logic center_reg;
	logic double_reg;
	logic paired_reg;
	logic start_reg;
	wire [MPWM_OUTS_PER_GROUP-1:0] cmp_hi;
	wire [MPWM_OUTS_PER_GROUP-1:0] outs_next;

	wire at_top = (cnt_reg >= period_reg);
	wire at_zero = (cnt_reg == MPWM_CNT_RESET);
	// period start loads everything; the midpoint loads duties only in double update
	wire period_end = center_reg ? (phase_reg == MPWM_PH_DOWN && cnt_reg <= 16'h0001) : at_top;
	wire load_start = (phase_reg == MPWM_PH_IDLE) || period_end; // see (RULE7) see (RULE10)
	wire load_mid = center_reg && double_reg && phase_reg == MPWM_PH_UP && at_top; // see (RULE6) see (RULE8)

	always_comb begin
		phase_next = phase_reg;
		cnt_next = cnt_reg;
		unique case (phase_reg)
			MPWM_PH_IDLE: begin
				phase_next = MPWM_PH_UP;
				cnt_next = MPWM_CNT_RESET;
			end
			MPWM_PH_UP: begin
				if (at_top) begin
					if (center_reg) begin // see (RULE9)
						phase_next = MPWM_PH_DOWN;
						cnt_next = cnt_reg - 16'h0001;
					end else begin
						cnt_next = MPWM_CNT_RESET; // see (RULE1)
					end
				end else begin
					cnt_next = cnt_reg + 16'h0001;
				end
			end
			MPWM_PH_DOWN: begin
				if (at_zero || cnt_reg == 16'h0001) begin
					phase_next = MPWM_PH_UP;
					cnt_next = MPWM_CNT_RESET;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			default: begin
				phase_next = MPWM_PH_IDLE;
				cnt_next = MPWM_CNT_RESET;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !gi.enable) begin
			phase_reg <= MPWM_PH_IDLE;
			cnt_reg <= MPWM_CNT_RESET;
			period_reg <= MPWM_PERIOD_RESET;
			center_reg <= 1'b0;
			double_reg <= 1'b0;
			paired_reg <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			cnt_reg <= cnt_next;
			start_reg <= load_start;
			if (load_start) begin
				period_reg <= gi.period;
				center_reg <= gi.center_mode;
				double_reg <= gi.double_update;
				paired_reg <= gi.paired;
			end
		end
	end

	// one process per register keeps a single driver on each array and vector
	always_ff @(posedge clk) begin
		for (int j = 0; j < MPWM_OUTS_PER_GROUP; j++) begin
			if (sys_rst || !gi.enable) begin
				act_reg[j] <= MPWM_DUTY_RESET;
			end else if (load_start || load_mid) begin
				act_reg[j] <= gi.duty[j]; // see (RULE10)
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !gi.enable || phase_reg == MPWM_PH_IDLE) begin
			outs_reg <= {MPWM_OUTS_PER_GROUP{1'b0}};
		end else begin
			outs_reg <= outs_next;
		end
	end

	genvar k;
	generate
		for (k = 0; k < MPWM_OUTS_PER_GROUP; k++) begin : g_ch
			// in paired mode the odd output of a pair is the inverse of the even one's compare
			localparam int SRC = k - (k % 2);
			assign cmp_hi[k] = cnt_reg < act_reg[k]; // see (RULE3) see (RULE9)
			assign outs_next[k] = (paired_reg && (k % 2) == 1) ? !cmp_hi[SRC] : cmp_hi[k]; // see (RULE2) see (RULE5)
		end
	endgenerate

	assign gi.outs = outs_reg;
	assign gi.period_start = start_reg;
endmodule // mpwm_group

// ===== hw/mpwm_top.sv
// top of the sixteen-output multi-group pwm generator
`timescale 1ns/100ps
// Notes on behaviour
// (RULE1) each group makes center-aligned or edge-aligned waveforms as software selects.
// (RULE2) in paired operation the two outputs of a pair are exact inverses.
// (RULE3) in non-paired operation all four outputs of a group are independent.
// (RULE4) four groups of four outputs give sixteen pwm outputs.
// (RULE5) each group arranges its four outputs as two pairs.
// (RULE6) single and double update apply to center-aligned waveforms and are the only two options.
// (RULE7) in single update new duties load once per period, giving symmetric pulses.
// (RULE8) in double update duties also load at the period midpoint, allowing asymmetric pulses.
// (RULE9) center-aligned groups count up then down and outputs toggle at the duty compare.
// (RULE10) written duties sit in shadow copies and reach the compare only at allowed update points.
module mpwm_top
	import mpwm_pkg::*;
#(
	parameter int GROUPS = MPWM_GROUPS
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [GROUPS-1:0] group_enable,
	input wire logic [GROUPS-1:0] center_mode,
	input wire logic [GROUPS-1:0] double_update,
	input wire logic [GROUPS-1:0] paired_mode,
	input wire logic [GROUPS*MPWM_CNT_W-1:0] period_value,
	input wire logic [GROUPS*MPWM_OUTS_PER_GROUP*MPWM_CNT_W-1:0] duty_value,
	output logic [GROUPS*MPWM_OUTS_PER_GROUP-1:0] pwm_out,
	output logic [GROUPS-1:0] period_start
);
	genvar g, c;
	generate
		for (g = 0; g < GROUPS; g++) begin : g_grp // see (RULE4)
			mpwm_group_if gif();
			assign gif.enable = group_enable[g];
			assign gif.center_mode = center_mode[g];
			assign gif.double_update = double_update[g];
			assign gif.paired = paired_mode[g];
			assign gif.period = period_value[g*MPWM_CNT_W +: MPWM_CNT_W];
			for (c = 0; c < MPWM_OUTS_PER_GROUP; c++) begin : g_d
				assign gif.duty[c] = duty_value[(g*MPWM_OUTS_PER_GROUP+c)*MPWM_CNT_W +: MPWM_CNT_W];
			end
			mpwm_group u_grp (
				.clk(clk),
				.sys_rst(sys_rst),
				.gi(gif)
			);
			// the group core registers both outputs, so these come straight from flip-flops
			assign pwm_out[g*MPWM_OUTS_PER_GROUP +: MPWM_OUTS_PER_GROUP] = gif.outs;
			assign period_start[g] = gif.period_start;
		end
	endgenerate
endmodule // mpwm_top

// ===== verification/mpwm_chk.sv
// port-level checks for the pwm top
`timescale 1ns/100ps
module mpwm_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] paired_mode,
	input wire logic [15:0] pwm_out,
	input wire logic [3:0] period_start
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// widths assume the bench set-up: group 0 edge P=9 duty 3, group 1 center P=8 duties 2 and 4
	sequence s_edge_hi;
		pwm_out[0][*3] ##1 !pwm_out[0];
	endsequence
	sequence s_indep_lo;
		!pwm_out[5][*8] ##1 !pwm_out[5] ##1 pwm_out[5];
	endsequence
	// thirteen low cycles split in two runs to keep each repetition short
	sequence s_center_lo;
		!pwm_out[4][*8] ##1 !pwm_out[4][*5] ##1 pwm_out[4];
	endsequence
	a_reset_outs_low: assert property ($fell(sys_rst) |->
		pwm_out == 16'h0000 && period_start == 4'h0)
		else $error("outputs active after reset");
	a_pair_inverse: assert property (period_start[0] && paired_mode[0] |=>
		pwm_out[1] != pwm_out[0] && pwm_out[3] != pwm_out[2])
		else $error("pair not complementary");
	a_start_pulse: assert property (period_start[1] |=> !period_start[1])
		else $error("period start longer than one cycle");
	a_edge_period: assert property (period_start[0] |-> ##10 period_start[0])
		else $error("edge period length wrong");
	a_center_period: assert property (period_start[1] |-> ##16 period_start[1])
		else $error("center period length wrong");
	a_edge_width: assert property ($rose(pwm_out[0]) |-> s_edge_hi)
		else $error("edge pulse width wrong");
	a_center_low: assert property ($fell(pwm_out[4]) |-> s_center_lo)
		else $error("center low time wrong");
	a_indep_out: assert property ($fell(pwm_out[5]) |-> s_indep_lo)
		else $error("independent output low time wrong");
endmodule // mpwm_chk

// ===== verification/mpwm_stage_model.sv
// bridge leg model: latches a shoot-through on pair 0
`timescale 1ns/100ps
module mpwm_stage_model (
	input wire logic clk,
	input wire logic [15:0] gate,
	output logic leg_short
);
	initial leg_short = 1'b0;
	always @(posedge clk) if (gate[0] && gate[1]) leg_short <= 1'b1;
endmodule // mpwm_stage_model

// ===== verification/mpwm_tb_top.sv
// testbench for the multi-group pwm generator
`timescale 1ns/100ps
module multi_group_pwm_generator_tb_top;
	logic clk, sys_rst, leg_short;
	logic [3:0] en, cm, du, pm, period_start;
	logic [63:0] per;
	logic [255:0] duty;
	logic [15:0] pwm_out;
	int num_errors, checks_done;
	mpwm_top mpwm_top_inst (.clk(clk), .sys_rst(sys_rst), .group_enable(en), .center_mode(cm), .double_update(du),
		.paired_mode(pm), .period_value(per), .duty_value(duty), .pwm_out(pwm_out), .period_start(period_start));
	mpwm_stage_model mpwm_stage_model_inst (.clk(clk), .gate(pwm_out), .leg_short(leg_short));
	task summarize;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cmp(string name, logic [15:0] exp, logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s exp %0d got %0d", name, exp, got);
		end
	endtask
	// one full period of group g: length and high cycles of output i
	// sel >= 0 rewrites that duty word, flip toggles the group's alignment, both on the period's first edge
	task meas(int g, int i, int len, int hi, int sel, logic [15:0] nd, bit flip);
		logic [15:0] n, h;
		int k;
		for (k = 0; k < 99 && period_start[g] !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 99) begin
			num_errors++;
			summarize();
		end
		n = 0;
		h = 0;
		do begin
			@(posedge clk);
			if (n == 16'h0000 && sel >= 0)
				duty[sel*16 +: 16] <= nd;
			if (n == 16'h0000 && flip)
				cm[g] <= !cm[g];
			#1;
			n++;
			h = h + {15'h0, pwm_out[i]};
		end while (period_start[g] !== 1'b1 && n < 99);
		cmp("period", len[15:0], n);
		cmp("high", hi[15:0], h);
	endtask
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	initial begin
		num_errors = 0;
		checks_done = 0;
		sys_rst <= 1;
		en <= 4'hF;
		cm <= 4'h6;
		du <= 4'hC;
		pm <= 4'h1;
		per <= {16'h0005, 16'h0008, 16'h0008, 16'h0009};
		duty <= {32'h0, 16'h0002, 16'h00FF, 48'h0, 16'h0003, 16'h0, 16'h0008, 16'h0004, 16'h0002, 48'h0, 16'h0003};
		repeat (12) @(posedge clk);
		sys_rst <= 0;
		meas(0, 0, 10, 3, -1, 16'h0000, 1'b0);
		meas(0, 1, 10, 7, -1, 16'h0000, 1'b0);
		meas(0, 3, 10, 10, -1, 16'h0000, 1'b0);
		meas(1, 4, 16, 3, -1, 16'h0000, 1'b0);
		meas(1, 5, 16, 7, -1, 16'h0000, 1'b0);
		meas(1, 6, 16, 15, -1, 16'h0000, 1'b0);
		meas(2, 8, 16, 5, -1, 16'h0000, 1'b0);
		meas(3, 12, 6, 6, -1, 16'h0000, 1'b0);
		meas(3, 13, 6, 2, -1, 16'h0000, 1'b0);
		// edge group with double update set: a mid-period duty write must wait for the period end
		meas(3, 12, 6, 6, 12, 16'h0001, 1'b0);
		meas(3, 12, 6, 1, -1, 16'h0000, 1'b0);
		// single update center group: the new duty shows only in the following period
		meas(1, 7, 16, 0, 7, 16'h0004, 1'b0);
		meas(1, 7, 16, 7, -1, 16'h0000, 1'b0);
		// double update: the midpoint load gives 3 high cycles on the way up and 4 on the way down
		meas(2, 8, 16, 7, 8, 16'h0005, 1'b0);
		meas(2, 8, 16, 9, -1, 16'h0000, 1'b0);
		// alignment change mid-period keeps the running edge period
		meas(3, 13, 6, 2, -1, 16'h0000, 1'b1);
		meas(3, 13, 10, 3, -1, 16'h0000, 1'b0);
		cmp("leg_short", 16'h0000, {15'h0, leg_short});
		summarize();
	end
endmodule // multi_group_pwm_generator_tb_top
bind mpwm_top mpwm_chk mpwm_chk_inst (.clk(clk), .sys_rst(sys_rst), .paired_mode(paired_mode), .pwm_out(pwm_out),
	.period_start(period_start));
